// ===== logic/beh_pkg.sv
// Contract
// [R1] No parity is generated or checked by the interface on bus transfers.
// [R2] Any CPU bus reference other than a longword access starts a machine check.
// [R3] Three timers: reply (nonexistent memory), DMA grant acknowledge, mastership at 10 ms.
// [R4] Reply timeout on demand read: set nonexistent flag, capture page, machine check.
// [R5] Reply timeout on prefetch or vector read: abort only, capture nothing, no check.
// [R6] Reply timeout on masked write: set flag, capture page, interrupt level 1D vector 60.
// [R7] Unacknowledged DMA grant: withdraw silently, wait 500 ns before arbitrating again.
// [R8] Mastership not won in 10 ms on demand read: set no-grant flag, machine check.
// [R9] During reads, data lines 17 and 16 carry the slave's parity error report.
// [R10] Parity report on demand read: set parity flag, capture page, machine check.
// [R11] Parity report on prefetch: abort, set parity flag, capture page, no machine check.
// [R12] Power-ok negation raises a power-fail trap through vector 0C.
// [R13] Power-ok level reads as bit 15 of the system configuration register.
// [R14] After the trap the interface works on until DC power-ok is negated.
// [R15] Error page register holds bus address bits 21..9 in bits 12..0, rest zero.
// [R16] A capturing error while a capturing flag is set sets the lost-error flag.
// [R17] Error flags clear by writing one, power-up, DC power-ok negation, I/O reset.
// [R18] Timers count clock cycles rounded up, restart per phase, stop on completion.
package beh_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int NOMEM_TIME_NS = 10000;
  localparam int SACK_TIME_NS = 10000;
  localparam int GRANT_TIME_NS = 10000000;
  localparam int GAP_TIME_NS = 500;
  localparam int NOMEM_CYCLES = (NOMEM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SACK_CYCLES = (SACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GRANT_CYCLES = (GRANT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYCLES = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ERRSTAT = 8'h04;
  localparam logic [7:0] OFS_PAGE = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0C;
  localparam logic [7:0] OFS_IO_RESET = 8'h10;
  localparam int ERR_NOMEM_BIT = 7;
  localparam int ERR_PAR_BIT = 5;
  localparam int ERR_LOST_BIT = 3;
  localparam int ERR_NOGNT_BIT = 2;
  localparam int CFG_PWROK_BIT = 15;
  localparam int PAGE_LSB = 9;
  localparam int PAGE_MSB = 21;
  localparam int PAR_LSB = 16;
  localparam int PAR_MSB = 17;
  localparam logic [12:0] PAGE_RESET = 13'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Interrupt and trap codes
  // ----------------------------------------------------------------
  localparam logic [4:0] INT_LEVEL = 5'h1D;
  localparam logic [15:0] INT_VEC = 16'h0060;
  localparam logic [15:0] TRAP_VEC = 16'h000C;

  typedef enum logic [1:0] {
    REF_DEMAND = 2'h0,
    REF_PREFETCH = 2'h1,
    REF_MWRITE = 2'h2,
    REF_INTACK = 2'h3
  } beh_ref_t;

  typedef enum logic [1:0] {
    MST_IDLE = 2'b00,
    MST_ARB = 2'b01,
    MST_XFER = 2'b11,
    MST_FIN = 2'b10
  } beh_mst_t;

  typedef enum logic [1:0] {
    DMA_IDLE = 2'b00,
    DMA_GNT = 2'b01,
    DMA_OWN = 2'b11,
    DMA_GAP = 2'b10
  } beh_dma_t;
endpackage

// ===== logic/beh_tmr_if.sv
`timescale 1ns/1ps
interface beh_tmr_if;
  logic start;
  logic run;
  logic expired;
  modport ctl (output start, output run, input expired);
  modport tmr (input start, input run, output expired);
endinterface

// ===== logic/beh_timer.sv
`timescale 1ns/1ps
module beh_timer #(
  parameter int LIMIT = 250
) (
  input wire logic clk,
  input wire logic rst_n,
  beh_tmr_if.tmr tif
);
  import beh_pkg::*;
  localparam int CW = $clog2(LIMIT + 1);

  if (LIMIT < 2)
  begin : g_bad_limit
    $error("beh_timer: LIMIT must be at least 2");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic exp;
  } beh_tmr_t;

  beh_tmr_t s_r;
  beh_tmr_t s_nxt;

  // Expiry is a level that holds until the owner restarts the timer
  always_comb
  begin
    s_nxt = s_r;
    if (tif.start)
    begin
      s_nxt.cnt = '0;
      s_nxt.exp = 1'b0;
    end
    else if (tif.run && !s_r.exp)
    begin
      if (s_r.cnt == CW'(LIMIT - 1))
        s_nxt.exp = 1'b1;
      else
        s_nxt.cnt = s_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tif.expired = s_r.exp && tif.run && !tif.start;
endmodule

// ===== logic/beh_top.sv
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module beh_top
  import beh_pkg::*;
#(
  parameter int NOMEM_LIMIT = beh_pkg::NOMEM_CYCLES,
  parameter int SACK_LIMIT = beh_pkg::SACK_CYCLES,
  parameter int GRANT_LIMIT = beh_pkg::GRANT_CYCLES
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic REF_VALID,
  input wire beh_pkg::beh_ref_t REF_KIND,
  input wire logic REF_LONG,
  input wire logic [21:0] REF_ADDR,
  output logic REF_DONE,
  output logic REF_ABORT,
  output logic REF_MCHK,
  output logic [15:0] REF_RDATA,
  output logic BUS_REQ,
  input wire logic BUS_MASTER_GNT,
  output logic BUS_SYNC,
  output logic BUS_WRITE,
  output logic [21:0] BUS_ADDR,
  input wire logic BUS_RPLY,
  input wire logic [21:0] BUS_DAL_IN,
  input wire logic DMA_REQ_IN,
  output logic DMA_GRANT,
  input wire logic DMA_SACK,
  output logic INT_REQ,
  output logic [4:0] INT_PRIO,
  output logic [15:0] INT_VECTOR,
  input wire logic INT_ACK,
  output logic PWRFAIL_TRAP,
  output logic [15:0] TRAP_VECTOR,
  input wire logic PWR_OK,
  input wire logic DC_OK
);
  import beh_pkg::*;

  if (NOMEM_LIMIT < 2 || SACK_LIMIT < 2 || GRANT_LIMIT < 2)
  begin : g_bad_limits
    $error("beh_top: timer limits must be at least 2");
  end

  typedef struct packed {
    beh_mst_t mst;
    beh_dma_t dma;
    beh_ref_t kind;
    logic [21:0] addr;
    logic [4:0] gap;
    logic f_nomem;
    logic f_par;
    logic f_lost;
    logic f_gnt;
    logic [12:0] page;
    logic done;
    logic abort;
    logic mchk;
    logic [15:0] rdata_ref;
    logic int_pend;
    logic trap;
    logic pwr_ok_d;
    logic ap_act;
    logic ap_wr;
    logic [7:0] ap_ofs;
    logic [31:0] rdata;
  } beh_state_t;

  beh_state_t s_r;
  beh_state_t s_nxt;
  logic start_nomem;
  logic start_sack;
  logic start_gnt;
  logic cap;
  logic [31:0] rd_val;
  logic wr_errstat;

  beh_tmr_if t_nomem ();
  beh_tmr_if t_sack ();
  beh_tmr_if t_gnt ();

  // ----------------------------------------------------------------
  // Watchdog timers
  // ----------------------------------------------------------------
  beh_timer #(.LIMIT(NOMEM_LIMIT)) u_nomem (.clk(CLK), .rst_n(RSTN), .tif(t_nomem.tmr)); // R3
  beh_timer #(.LIMIT(SACK_LIMIT)) u_sack (.clk(CLK), .rst_n(RSTN), .tif(t_sack.tmr)); // R3
  beh_timer #(.LIMIT(GRANT_LIMIT)) u_gnt (.clk(CLK), .rst_n(RSTN), .tif(t_gnt.tmr)); // R3

  assign t_nomem.start = start_nomem; // R18
  assign t_sack.start = start_sack; // R18
  assign t_gnt.start = start_gnt; // R18
  assign t_nomem.run = (s_r.mst == MST_XFER); // R18
  assign t_sack.run = (s_r.dma == DMA_GNT); // R18
  assign t_gnt.run = (s_r.mst == MST_ARB); // R18

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.abort = 1'b0;
    s_nxt.mchk = 1'b0;
    s_nxt.trap = 1'b0;
    start_nomem = 1'b0;
    start_sack = 1'b0;
    start_gnt = 1'b0;
    cap = 1'b0;
    s_nxt.pwr_ok_d = PWR_OK;
    // The trap is a notice only; the bus logic keeps running
    if (s_r.pwr_ok_d && !PWR_OK)
      s_nxt.trap = 1'b1; // R12 R14

    // Read data is formed in the address phase so that it leaves a flop
    rd_val = '0;
    unique case (HADDR[7:0])
      OFS_ERRSTAT:
      begin
        rd_val[ERR_NOMEM_BIT] = s_r.f_nomem;
        rd_val[ERR_PAR_BIT] = s_r.f_par;
        rd_val[ERR_LOST_BIT] = s_r.f_lost;
        rd_val[ERR_NOGNT_BIT] = s_r.f_gnt;
      end
      OFS_PAGE: rd_val[12:0] = s_r.page; // R15
      OFS_CFG: rd_val[CFG_PWROK_BIT] = PWR_OK; // R13
      default: rd_val = '0;
    endcase
    s_nxt.ap_act = HSEL && HTRANS[1] && HREADY;
    if (s_nxt.ap_act)
    begin
      s_nxt.ap_wr = HWRITE;
      s_nxt.ap_ofs = HADDR[7:0];
      if (!HWRITE)
        s_nxt.rdata = rd_val;
    end

    // Software clears first so that a hardware set in the same cycle wins
    wr_errstat = s_r.ap_act && s_r.ap_wr && (s_r.ap_ofs == OFS_ERRSTAT);
    if (wr_errstat)
    begin
      if (HWDATA[ERR_NOMEM_BIT]) s_nxt.f_nomem = 1'b0; // R17
      if (HWDATA[ERR_PAR_BIT]) s_nxt.f_par = 1'b0; // R17
      if (HWDATA[ERR_LOST_BIT]) s_nxt.f_lost = 1'b0; // R17
      if (HWDATA[ERR_NOGNT_BIT]) s_nxt.f_gnt = 1'b0; // R17
    end
    if ((s_r.ap_act && s_r.ap_wr && s_r.ap_ofs == OFS_IO_RESET) || !DC_OK)
    begin
      s_nxt.f_nomem = 1'b0; // R17
      s_nxt.f_par = 1'b0;
      s_nxt.f_lost = 1'b0;
      s_nxt.f_gnt = 1'b0;
    end
    if (INT_ACK)
      s_nxt.int_pend = 1'b0;

    // ----------------------------------------------------------------
    // CPU reference sequencer
    // ----------------------------------------------------------------
    unique case (s_r.mst)
      MST_IDLE:
        if (REF_VALID && DC_OK)
        begin
          s_nxt.kind = REF_KIND;
          s_nxt.addr = REF_ADDR;
          if (!REF_LONG)
          begin
            s_nxt.mst = MST_FIN; // R2
            s_nxt.done = 1'b1;
            s_nxt.abort = 1'b1;
            s_nxt.mchk = 1'b1;
          end
          else
          begin
            s_nxt.mst = MST_ARB;
            start_gnt = 1'b1; // R18
          end
        end
      MST_ARB:
        if (BUS_MASTER_GNT && s_r.dma == DMA_IDLE)
        begin
          s_nxt.mst = MST_XFER;
          start_nomem = 1'b1; // R18
        end
        else if (t_gnt.expired)
        begin
          s_nxt.mst = MST_FIN;
          s_nxt.done = 1'b1;
          s_nxt.abort = 1'b1;
          if (s_r.kind == REF_DEMAND)
          begin
            s_nxt.f_gnt = 1'b1; // R8
            s_nxt.mchk = 1'b1; // R8
          end
        end
      MST_XFER:
        if (BUS_RPLY)
        begin
          s_nxt.mst = MST_FIN;
          s_nxt.done = 1'b1;
          s_nxt.rdata_ref = BUS_DAL_IN[15:0];
          // Parity is only read back from the slave, never computed here
          if (s_r.kind != REF_MWRITE && BUS_DAL_IN[PAR_MSB:PAR_LSB] != 2'b00) // R1 R9
          begin
            s_nxt.abort = 1'b1;
            if (s_r.kind == REF_DEMAND)
            begin
              s_nxt.f_par = 1'b1; // R10
              s_nxt.mchk = 1'b1; // R10
              cap = 1'b1;
            end
            else if (s_r.kind == REF_PREFETCH)
            begin
              s_nxt.f_par = 1'b1; // R11
              cap = 1'b1; // R11
            end
          end
        end
        else if (t_nomem.expired)
        begin
          s_nxt.mst = MST_FIN;
          s_nxt.done = 1'b1;
          s_nxt.abort = (s_r.kind != REF_MWRITE); // R5
          if (s_r.kind == REF_DEMAND)
          begin
            s_nxt.f_nomem = 1'b1; // R4
            s_nxt.mchk = 1'b1; // R4
            cap = 1'b1;
          end
          else if (s_r.kind == REF_MWRITE)
          begin
            s_nxt.f_nomem = 1'b1; // R6
            s_nxt.int_pend = 1'b1; // R6
            cap = 1'b1;
          end
        end
      MST_FIN:
        s_nxt.mst = MST_IDLE;
    endcase

    // An older capture is kept; the newer error only marks the loss
    if (cap)
    begin
      if (s_r.f_nomem || s_r.f_par)
        s_nxt.f_lost = 1'b1; // R16
      else
        s_nxt.page = s_r.addr[PAGE_MSB:PAGE_LSB]; // R15
    end

    // ----------------------------------------------------------------
    // DMA grant sequencer
    // ----------------------------------------------------------------
    unique case (s_r.dma)
      DMA_IDLE:
        if (DMA_REQ_IN && s_r.mst == MST_IDLE && !REF_VALID)
        begin
          s_nxt.dma = DMA_GNT;
          start_sack = 1'b1; // R18
        end
      DMA_GNT:
        if (DMA_SACK)
          s_nxt.dma = DMA_OWN;
        else if (t_sack.expired)
        begin
          s_nxt.dma = DMA_GAP; // R7
          s_nxt.gap = '0;
        end
      DMA_OWN:
        if (!DMA_SACK)
          s_nxt.dma = DMA_IDLE;
      DMA_GAP:
        // Lets the grant ripple out of the daisy chain before a new one
        if (s_r.gap == 5'(GAP_CYCLES - 1))
          s_nxt.dma = DMA_IDLE; // R7
        else
          s_nxt.gap = s_r.gap + 5'h01;
    endcase

    if (!DC_OK)
    begin
      s_nxt.mst = MST_IDLE; // R14
      s_nxt.dma = DMA_IDLE;
      s_nxt.int_pend = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s_r <= '0;
      s_r.page <= PAGE_RESET;
      s_r.rdata <= RDATA_RESET;
      s_r.pwr_ok_d <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = s_r.rdata;
  assign REF_DONE = s_r.done;
  assign REF_ABORT = s_r.abort;
  assign REF_MCHK = s_r.mchk;
  assign REF_RDATA = s_r.rdata_ref;
  assign BUS_REQ = (s_r.mst == MST_ARB);
  assign BUS_SYNC = (s_r.mst == MST_XFER);
  assign BUS_WRITE = (s_r.kind == REF_MWRITE);
  assign BUS_ADDR = s_r.addr;
  assign DMA_GRANT = (s_r.dma == DMA_GNT) || (s_r.dma == DMA_OWN);
  assign INT_REQ = s_r.int_pend;
  assign INT_PRIO = INT_LEVEL;
  assign INT_VECTOR = INT_VEC;
  assign PWRFAIL_TRAP = s_r.trap;
  assign TRAP_VECTOR = TRAP_VEC;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_illegal;
    @(posedge CLK) disable iff (!RSTN)
    (s_r.mst == MST_IDLE && REF_VALID && DC_OK && !REF_LONG) |=> (REF_DONE && REF_ABORT && REF_MCHK);
  endproperty
  a_illegal: assert property (p_illegal) else $error("short reference not rejected"); // R2

  property p_nomem_demand;
    @(posedge CLK) disable iff (!RSTN)
    (s_r.mst == MST_XFER && !BUS_RPLY && t_nomem.expired && s_r.kind == REF_DEMAND && DC_OK)
      |=> (s_r.f_nomem && REF_MCHK && REF_ABORT);
  endproperty
  a_nomem_demand: assert property (p_nomem_demand) else $error("demand timeout not flagged"); // R4

  property p_nomem_quiet;
    @(posedge CLK) disable iff (!RSTN)
    (s_r.mst == MST_XFER && !BUS_RPLY && t_nomem.expired && (s_r.kind == REF_PREFETCH || s_r.kind == REF_INTACK))
      |=> (REF_ABORT && !REF_MCHK && $stable(s_r.page));
  endproperty
  a_nomem_quiet: assert property (p_nomem_quiet) else $error("prefetch timeout not silent"); // R5

  property p_nomem_write;
    @(posedge CLK) disable iff (!RSTN)
    (s_r.mst == MST_XFER && !BUS_RPLY && t_nomem.expired && s_r.kind == REF_MWRITE && DC_OK)
      |=> (INT_REQ && s_r.f_nomem && INT_PRIO == 5'h1D && INT_VECTOR == 16'h0060);
  endproperty
  a_nomem_write: assert property (p_nomem_write) else $error("write timeout gave no interrupt"); // R6

  property p_gap;
    @(posedge CLK) disable iff (!RSTN)
    (s_r.dma == DMA_GNT && !DMA_SACK && t_sack.expired && DC_OK) |=> !DMA_GRANT [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("grant reissued too soon"); // R7

  property p_nogrant;
    @(posedge CLK) disable iff (!RSTN)
    (s_r.mst == MST_ARB && t_gnt.expired && !(BUS_MASTER_GNT && s_r.dma == DMA_IDLE)
      && s_r.kind == REF_DEMAND && DC_OK) |=> (s_r.f_gnt && REF_MCHK);
  endproperty
  a_nogrant: assert property (p_nogrant) else $error("mastership timeout not flagged"); // R8

  property p_parity;
    @(posedge CLK) disable iff (!RSTN)
    (s_r.mst == MST_XFER && BUS_RPLY && BUS_DAL_IN[17:16] != 2'b00 && s_r.kind == REF_DEMAND && DC_OK)
      |=> (s_r.f_par && REF_MCHK) ##1 (s_r.mst == MST_IDLE);
  endproperty
  a_parity: assert property (p_parity) else $error("parity report missed"); // R10

  property p_trap;
    @(posedge CLK) disable iff (!RSTN)
    $fell(PWR_OK) |=> (PWRFAIL_TRAP && TRAP_VECTOR == 16'h000C);
  endproperty
  a_trap: assert property (p_trap) else $error("power-fail trap missing"); // R12

  property p_lost;
    @(posedge CLK) disable iff (!RSTN)
    (cap && (s_r.f_nomem || s_r.f_par) && DC_OK) |=> (s_r.f_lost && $stable(s_r.page));
  endproperty
  a_lost: assert property (p_lost) else $error("lost error not recorded"); // R16

  c_parity: cover property (@(posedge CLK) disable iff (!RSTN) s_r.f_par && REF_MCHK);
  c_write_int: cover property (@(posedge CLK) disable iff (!RSTN) $rose(INT_REQ));
  c_sack_gap: cover property (@(posedge CLK) disable iff (!RSTN) s_r.dma == DMA_GAP);
  c_lost: cover property (@(posedge CLK) disable iff (!RSTN) $rose(s_r.f_lost));
endmodule

// ===== tb/beh_bus_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far side: arbiter and one slave whose reply can be slow, missing or flag a parity error
// ----------------------------------------
module beh_bus_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic sync,
  input wire logic [21:0] addr,
  input wire logic gnt_en,
  input wire logic rply_en,
  input wire logic par_err,
  input wire logic [3:0] delay,
  output logic gnt,
  output logic rply,
  output logic [21:0] dal
);
  logic [3:0] cnt;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gnt <= 1'h0;
      rply <= 1'h0;
      cnt <= 4'h0;
      dal <= 22'h0;
    end
    else
    begin
      gnt <= req & gnt_en;
      if (sync && rply_en && cnt == delay)
      begin
        rply <= 1'h1;
        dal <= {4'h0, {2{par_err}}, addr[15:0] ^ 16'h5A5A};
      end
      else if (!sync)
      begin
        rply <= 1'h0;
        dal <= ~dal; // Released lines have no pull: never leave the old value standing
      end
      if (!sync)
        cnt <= 4'h0;
      else if (cnt != delay)
        cnt <= cnt + 4'h1;
    end
  end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import beh_pkg::*;
  localparam int NOMEM_L = 20;
  localparam int SACK_L = 20;
  localparam int GRANT_L = 40;
  logic clk = 1'h0;
  logic rstn, hready, hreadyout, hresp, hwrite, ref_valid, ref_long, ref_done, ref_abort, ref_mchk;
  logic bus_req, gnt, bus_sync, bus_write, rply, dma_req, dma_grant, dma_sack, int_req, int_ack;
  logic trap, pwr_ok, dc_ok, gnt_en, rply_en, par_err;
  logic [1:0] htrans;
  logic [3:0] delay;
  logic [4:0] int_prio;
  logic [15:0] ref_rdata, int_vector, trap_vector, rdat;
  logic [21:0] ref_addr, bus_addr, dal;
  logic [31:0] haddr, hwdata, hrdata, v;
  beh_ref_t ref_kind;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc, n;

  assign hready = hreadyout;
  always #20 clk = ~clk;

  beh_top #(.NOMEM_LIMIT(NOMEM_L), .SACK_LIMIT(SACK_L), .GRANT_LIMIT(GRANT_L)) beh_top_inst (
    .CLK(clk), .RSTN(rstn), .HSEL(1'h1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
    .REF_VALID(ref_valid), .REF_KIND(ref_kind), .REF_LONG(ref_long), .REF_ADDR(ref_addr),
    .REF_DONE(ref_done), .REF_ABORT(ref_abort), .REF_MCHK(ref_mchk), .REF_RDATA(ref_rdata),
    .BUS_REQ(bus_req), .BUS_MASTER_GNT(gnt), .BUS_SYNC(bus_sync), .BUS_WRITE(bus_write),
    .BUS_ADDR(bus_addr), .BUS_RPLY(rply), .BUS_DAL_IN(dal), .DMA_REQ_IN(dma_req), .DMA_GRANT(dma_grant),
    .DMA_SACK(dma_sack), .INT_REQ(int_req), .INT_PRIO(int_prio), .INT_VECTOR(int_vector), .INT_ACK(int_ack),
    .PWRFAIL_TRAP(trap), .TRAP_VECTOR(trap_vector), .PWR_OK(pwr_ok), .DC_OK(dc_ok)
  );

  beh_bus_model beh_bus_model_inst (
    .clk(clk), .rst_n(rstn), .req(bus_req), .sync(bus_sync), .addr(bus_addr), .gnt_en(gnt_en),
    .rply_en(rply_en), .par_err(par_err), .delay(delay), .gnt(gnt), .rply(rply), .dal(dal)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask

  task automatic rdy();
    @(posedge clk);
    while (hready !== 1'h1)
      @(posedge clk);
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'h0, a, 32'h0, v);
    chk(v, e);
  endtask

  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, a, d, v);
  endtask

  function automatic logic [31:0] pg(input logic [21:0] a);
    return {19'h0, a[21:9]};
  endfunction

  // Holds the reference until done is sampled, then leaves one idle cycle
  task automatic cref(input beh_ref_t k, input logic lng, input logic [21:0] a, input logic [1:0] e);
    ref_valid <= 1'h1;
    ref_kind <= k;
    ref_long <= lng;
    ref_addr <= a;
    cyc = 0;
    do
    begin
      @(posedge clk);
      cyc++;
    end
    while (ref_done !== 1'h1 && cyc < 1000);
    chk({30'h0, ref_abort, ref_mchk}, {30'h0, e});
    rdat = ref_rdata;
    ref_valid <= 1'h0;
    @(posedge clk);
  endtask

  task automatic grant_is(input logic g);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (dma_grant !== g && n < 500);
  endtask

  task automatic endt(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    {hwrite, ref_valid, ref_long, dma_req, dma_sack, int_ack, par_err} = 7'h0;
    {htrans, delay, haddr, hwdata, ref_addr} = 92'h0;
    ref_kind = REF_DEMAND;
    {pwr_ok, dc_ok, gnt_en, rply_en} = 4'hF;
    rstn = 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    ok(hresp === 1'h0);
    rdc(OFS_ERRSTAT, 32'h0);
    rdc(OFS_PAGE, 32'h0);
    ahb(1'h0, OFS_CFG, 32'h0, v);
    chk(v & 32'h8000, 32'h8000);
    rdc(8'h40, 32'h0);
    delay <= 4'h2;
    cref(REF_DEMAND, 1'h1, 22'h12_3456, 2'h0);
    chk({16'h0, rdat}, {16'h0, 16'h3456 ^ 16'h5A5A});
    chk({9'h0, bus_write, bus_addr}, 32'h0012_3456);
    delay <= 4'h0;
    for (int i = 0; i < 4; i++)
      cref(beh_ref_t'(i), 1'h0, 22'h00_1000, 2'h3);
    endt("size");
    rply_en <= 1'h0;
    cref(REF_DEMAND, 1'h1, 22'h2A_5E00, 2'h3);
    ok(cyc > NOMEM_L && cyc < NOMEM_L + 8);
    rdc(OFS_ERRSTAT, 32'h80);
    rdc(OFS_PAGE, pg(22'h2A_5E00));
    cref(REF_DEMAND, 1'h1, 22'h01_0200, 2'h3);
    rdc(OFS_ERRSTAT, 32'h88);
    rdc(OFS_PAGE, pg(22'h2A_5E00));
    wrr(OFS_ERRSTAT, 32'h88);
    rdc(OFS_ERRSTAT, 32'h0);
    for (int i = 1; i < 4; i += 2)
      cref(beh_ref_t'(i), 1'h1, 22'h03_0000, 2'h2);
    rdc(OFS_ERRSTAT, 32'h0);
    rdc(OFS_PAGE, pg(22'h2A_5E00));
    cref(REF_MWRITE, 1'h1, 22'h3F_FE00, 2'h0);
    chk({9'h0, bus_write, bus_addr}, 32'h007F_FE00);
    ok(int_req === 1'h1 && int_prio === 5'h1D && int_vector === 16'h0060);
    rdc(OFS_ERRSTAT, 32'h80);
    rdc(OFS_PAGE, pg(22'h3F_FE00));
    int_ack <= 1'h1;
    @(posedge clk);
    int_ack <= 1'h0;
    repeat (2) @(posedge clk);
    ok(int_req === 1'h0);
    wrr(OFS_ERRSTAT, 32'h80);
    endt("timeout");
    {rply_en, par_err} <= 2'h3;
    cref(REF_DEMAND, 1'h1, 22'h15_5400, 2'h3);
    rdc(OFS_ERRSTAT, 32'h20);
    rdc(OFS_PAGE, pg(22'h15_5400));
    wrr(OFS_IO_RESET, 32'h1);
    rdc(OFS_ERRSTAT, 32'h0);
    cref(REF_PREFETCH, 1'h1, 22'h0A_AA00, 2'h2);
    rdc(OFS_ERRSTAT, 32'h20);
    rdc(OFS_PAGE, pg(22'h0A_AA00));
    wrr(OFS_ERRSTAT, 32'h20);
    par_err <= 1'h0;
    endt("parity");
    gnt_en <= 1'h0;
    cref(REF_DEMAND, 1'h1, 22'h00_0400, 2'h3);
    ok(cyc >= GRANT_L && cyc < GRANT_L + 8);
    rdc(OFS_ERRSTAT, 32'h04);
    wrr(OFS_ERRSTAT, 32'h04);
    gnt_en <= 1'h1;
    endt("nogrant");
    dma_req <= 1'h1;
    grant_is(1'h1);
    grant_is(1'h0);
    ok(n >= SACK_L - 1 && n <= SACK_L + 2);
    grant_is(1'h1);
    ok(n >= GAP_CYCLES);
    dma_sack <= 1'h1;
    repeat (SACK_L + 4) @(posedge clk);
    ok(dma_grant === 1'h1);
    {dma_req, dma_sack} <= 2'h0;
    grant_is(1'h0);
    ok(n < 3);
    rdc(OFS_ERRSTAT, 32'h0);
    endt("dma");
    pwr_ok <= 1'h0;
    n = 0;
    repeat (4)
    begin
      @(posedge clk);
      if (trap === 1'h1 && trap_vector === TRAP_VEC)
        n++;
    end
    chk(32'(n), 32'h1);
    ahb(1'h0, OFS_CFG, 32'h0, v);
    chk(v & 32'h8000, 32'h0);
    cref(REF_DEMAND, 1'h1, 22'h12_3456, 2'h0);
    chk({16'h0, rdat}, {16'h0, 16'h3456 ^ 16'h5A5A});
    par_err <= 1'h1;
    cref(REF_DEMAND, 1'h1, 22'h15_5400, 2'h3);
    par_err <= 1'h0;
    dc_ok <= 1'h0;
    repeat (2) @(posedge clk);
    dc_ok <= 1'h1;
    @(posedge clk);
    rdc(OFS_ERRSTAT, 32'h0);
    endt("power");
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule
